// File: pkg/sewp_pkg.sv
// Constants and types for the two-wire write-protected byte array slave.
// Assumes a 50 MHz system clock; the serial clock comes from the master.
package sewp_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ    = 50;
    localparam int unsigned T_WR_US    = 5000;
    localparam int unsigned WR_CYC     = T_WR_US * CLK_MHZ;

    // ==========================================================
    // Array geometry and frame layout
    localparam int unsigned MEM_BYTES  = 256;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned DATA_BITS  = 8;
    localparam logic [3:0]  ACK_SLOT   = 4'h8;
    localparam int unsigned PROT_BIT   = 7;
    localparam int unsigned SEL_MSB    = 7;
    localparam int unsigned SEL_LSB    = 4;
    localparam int unsigned STRAP_MSB  = 3;
    localparam int unsigned STRAP_LSB  = 1;
    localparam int unsigned RW_BIT     = 0;

    // ==========================================================
    // Selector and command codes
    localparam logic [3:0]  SEL_ARRAY  = 4'ha;
    localparam logic [3:0]  SEL_WP     = 4'h6;
    localparam logic [3:0]  SEL_TEMP   = 4'h3;
    localparam logic [7:0]  CMD_REV_SET = 8'h62;
    localparam logic [7:0]  CMD_REV_CLR = 8'h66;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_WORD  = 3'b011,
        ST_DATA  = 3'b010,
        ST_WRITE = 3'b110,
        ST_SKIP  = 3'b100
    } sewp_state_type;

    typedef enum logic [1:0] {
        OP_ARRAY   = 2'h0,
        OP_PERM    = 2'h1,
        OP_REV_SET = 2'h2,
        OP_REV_CLR = 2'h3
    } sewp_op_type;

    typedef struct packed {
        logic high_voltage_level;
        logic strap_sel_hi;
        logic strap_sel_mid;
        logic strap_sel_lo;
    } sewp_strap_type;

    typedef struct packed {
        logic standby;
        logic busy;
        logic perm_wp;
        logic rev_wp;
    } sewp_status_type;

endpackage

// File: rtl/sewp_slave.sv
// Two-wire slave front end for a 256-byte write-protected byte array.
// Assumes scl_clk is the master's serial clock, used as the link clock,
// and that the board resolves the open-drain data wire from sda_oe.
`timescale 1ns/1ps

module sewp_slave
    import sewp_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WR_CYC
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            scl_clk,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe,
    input  wire sewp_strap_type  strap_pins,
    input  wire logic            nv_perm_in,
    input  wire logic [7:0]      dbg_addr,
    output logic [7:0]           dbg_data,
    output sewp_status_type      status
);

    localparam int unsigned TW = $clog2(WR_CYCLES + 1);

    function automatic logic agree(input logic s2, input logic s3,
                                   input logic old);
        agree = (s2 == s3) ? s2 : old;
    endfunction

    function automatic logic protected_at(input logic [7:0] a,
                                          input logic perm,
                                          input logic rev);
        protected_at = (perm | rev) & ~a[PROT_BIT];
    endfunction

    // ==========================================================
    // Link domain: bit shifter and acknowledge driver
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] rx_byte_r;
    logic       byte_tgl_r;
    logic       start_seen_r;
    logic       sda_oe_r;
    logic       start_tgl_r;
    logic       ack_en_r;

    // Start toggle settles during the start hold time, long before
    // the next rising serial clock edge, so it is sampled directly.
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r    <= 4'h0;
            shift_r      <= 8'h00;
            rx_byte_r    <= 8'h00;
            byte_tgl_r   <= 1'b0;
            start_seen_r <= 1'b0;
        end else if (start_seen_r != start_tgl_r) begin
            start_seen_r <= start_tgl_r;
            shift_r      <= {7'h00, sda_i};
            bit_cnt_r    <= 4'h1;
        end else if (bit_cnt_r == ACK_SLOT) begin
            bit_cnt_r    <= 4'h0;
        end else begin
            shift_r      <= {shift_r[6:0], sda_i};
            bit_cnt_r    <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == ACK_SLOT - 4'h1) begin
                rx_byte_r  <= {shift_r[6:0], sda_i};
                byte_tgl_r <= ~byte_tgl_r;
            end
        end
    end

    // Acknowledge level is stable: it changes only per received byte
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= (bit_cnt_r == ACK_SLOT) && ack_en_r;
        end
    end

    assign sda_oe = sda_oe_r;
    assign sda_o  = 1'b0;

    // ==========================================================
    // System domain: pin synchronisers and framing detection
    logic [2:0]     scl_s_r;
    logic [2:0]     sda_s_r;
    logic [2:0]     tgl_s_r;
    sewp_strap_type strap_s1_r;
    sewp_strap_type strap_s2_r;
    sewp_strap_type strap_s3_r;
    sewp_strap_type strap_f_r;
    logic           scl_f_r;
    logic           sda_f_r;
    logic           tgl_f_r;
    logic           start_ev_r;
    logic           stop_ev_r;
    logic           byte_ev_r;
    logic           scl_nxt;
    logic           sda_nxt;
    logic           tgl_nxt;

    assign scl_nxt = agree(scl_s_r[1], scl_s_r[2], scl_f_r);
    assign sda_nxt = agree(sda_s_r[1], sda_s_r[2], sda_f_r);
    assign tgl_nxt = agree(tgl_s_r[1], tgl_s_r[2], tgl_f_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_r    <= 3'h7;
            sda_s_r    <= 3'h7;
            tgl_s_r    <= 3'h0;
            scl_f_r    <= 1'b1;
            sda_f_r    <= 1'b1;
            tgl_f_r    <= 1'b0;
            start_ev_r <= 1'b0;
            stop_ev_r  <= 1'b0;
            byte_ev_r  <= 1'b0;
        end else begin
            scl_s_r    <= {scl_s_r[1:0], scl_clk};
            sda_s_r    <= {sda_s_r[1:0], sda_i};
            tgl_s_r    <= {tgl_s_r[1:0], byte_tgl_r};
            scl_f_r    <= scl_nxt;
            sda_f_r    <= sda_nxt;
            tgl_f_r    <= tgl_nxt;
            // Clock high before and after: the acknowledge moves with
            // the falling clock and must not look like framing
            start_ev_r <= scl_f_r & scl_nxt & sda_f_r
                          & ~sda_nxt;
            stop_ev_r  <= scl_f_r & scl_nxt & ~sda_f_r
                          & sda_nxt;
            byte_ev_r  <= tgl_nxt ^ tgl_f_r;
        end
    end

    // Straps, including the separate high-voltage detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            strap_s3_r <= '0;
            strap_f_r  <= '0;
        end else begin
            strap_s1_r <= strap_pins;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            for (int i = 0; i < 4; i++) begin
                strap_f_r[i] <= agree(strap_s2_r[i], strap_s3_r[i],
                                      strap_f_r[i]);
            end
        end
    end

    // ==========================================================
    // Address byte decode
    sewp_state_type state_r;
    sewp_op_type    op_r;
    logic [7:0]     waddr_r;
    logic [15:0]    mask_r;
    logic [TW-1:0]  timer_r;
    logic           perm_r;
    logic           rev_r;
    logic           loaded_r;
    logic           dev_ack;
    sewp_op_type    dev_op;
    sewp_state_type dev_next;
    logic [3:0]     sel;
    logic           match;
    logic           is_set;
    logic           is_clr;
    logic           go_write;

    assign sel    = rx_byte_r[SEL_MSB:SEL_LSB];
    assign match  = rx_byte_r[STRAP_MSB:STRAP_LSB] ==
                    {strap_f_r.strap_sel_hi, strap_f_r.strap_sel_mid,
                     strap_f_r.strap_sel_lo};
    assign is_set = (rx_byte_r == CMD_REV_SET) && !strap_f_r.strap_sel_hi
                    && !strap_f_r.strap_sel_mid
                    && strap_f_r.high_voltage_level;
    assign is_clr = (rx_byte_r == CMD_REV_CLR) && !strap_f_r.strap_sel_hi
                    && strap_f_r.strap_sel_mid
                    && strap_f_r.high_voltage_level;

    always_comb begin
        dev_ack  = 1'b0;
        dev_op   = OP_ARRAY;
        dev_next = ST_IDLE;
        if (sel == SEL_ARRAY && match) begin
            dev_ack  = 1'b1;
            dev_next = rx_byte_r[RW_BIT] ? ST_SKIP : ST_WORD;
        end else if (sel == SEL_WP && !perm_r && !rx_byte_r[RW_BIT]) begin
            // Protect selector disappears once permanent
            if (is_set) begin
                dev_ack  = 1'b1;
                dev_op   = OP_REV_SET;
                dev_next = ST_WORD;
            end else if (is_clr) begin
                dev_ack  = 1'b1;
                dev_op   = OP_REV_CLR;
                dev_next = ST_WORD;
            end else if (match) begin
                dev_ack  = 1'b1;
                dev_op   = OP_PERM;
                dev_next = ST_WORD;
            end
        end
    end

    // Stop after at least one data byte launches the write cycle
    assign go_write = stop_ev_r && (state_r == ST_DATA) && (|mask_r);

    // ==========================================================
    // Transfer sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= ST_IDLE;
            op_r     <= OP_ARRAY;
            ack_en_r <= 1'b0;
        end else if (state_r == ST_WRITE) begin
            ack_en_r <= 1'b0;
            if (timer_r == '0) begin
                state_r <= ST_IDLE;
            end
        end else if (start_ev_r) begin
            state_r  <= ST_DEV;
            ack_en_r <= 1'b0;
        end else if (stop_ev_r) begin
            state_r  <= go_write ? ST_WRITE : ST_IDLE;
            ack_en_r <= 1'b0;
        end else if (byte_ev_r) begin
            unique case (state_r)
                ST_DEV: begin
                    ack_en_r <= dev_ack;
                    op_r     <= dev_op;
                    state_r  <= dev_next;
                end
                ST_WORD: begin
                    ack_en_r <= 1'b1;
                    state_r  <= ST_DATA;
                end
                ST_DATA: begin
                    ack_en_r <= 1'b1;
                end
                default: begin
                    ack_en_r <= 1'b0;
                end
            endcase
        end
    end

    // Word address and in-page increment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waddr_r <= 8'h00;
        end else if (byte_ev_r && state_r == ST_WORD) begin
            waddr_r <= rx_byte_r;
        end else if (byte_ev_r && state_r == ST_DATA) begin
            waddr_r[3:0] <= waddr_r[3:0] + 4'h1;
        end
    end

    // ==========================================================
    // Page buffer and array
    logic [7:0] page_r [PAGE_BYTES];
    logic [7:0] mem_r  [MEM_BYTES];
    logic [7:0] dbg_data_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 16'h0000;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_r[i] <= 8'h00;
            end
        end else if (start_ev_r && state_r != ST_WRITE) begin
            mask_r <= 16'h0000;
        end else if (byte_ev_r && state_r == ST_DATA) begin
            // Later bytes at the same slot overwrite earlier ones
            page_r[waddr_r[3:0]] <= rx_byte_r;
            mask_r[waddr_r[3:0]] <= 1'b1;
        end
    end

    // Array commits at write start; contents are not reset
    always_ff @(posedge clk) begin
        if (go_write && op_r == OP_ARRAY &&
            !protected_at(waddr_r, perm_r, rev_r)) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_r[i]) begin
                    mem_r[{waddr_r[7:4], 4'(i)}] <= page_r[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_data_r <= 8'h00;
        end else begin
            dbg_data_r <= mem_r[dbg_addr];
        end
    end

    assign dbg_data = dbg_data_r;

    // ==========================================================
    // Self-timed write cycle, same length whether protected or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= '0;
        end else if (go_write) begin
            timer_r <= TW'(WR_CYCLES - 1);
        end else if (state_r == ST_WRITE && timer_r != '0) begin
            timer_r <= timer_r - TW'(1);
        end
    end

    // ==========================================================
    // Protection flags; permanent state kept by an outside cell
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perm_r   <= 1'b0;
            rev_r    <= 1'b0;
            loaded_r <= 1'b0;
        end else if (!loaded_r) begin
            loaded_r <= 1'b1;
            perm_r   <= nv_perm_in;
        end else if (go_write) begin
            if (op_r == OP_PERM) begin
                perm_r <= 1'b1;
            end
            if (op_r == OP_REV_SET) begin
                rev_r <= 1'b1;
            end
            if (op_r == OP_REV_CLR) begin
                rev_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl_r <= 1'b0;
        end else if (start_ev_r && state_r != ST_WRITE) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    assign status.standby = (state_r == ST_IDLE);
    assign status.busy    = (state_r == ST_WRITE);
    assign status.perm_wp = perm_r;
    assign status.rev_wp  = rev_r;

    // ==========================================================
    // Assertions
    property p_start_dev;
        @(posedge clk) disable iff (!rst_n)
        (start_ev_r && state_r != ST_WRITE) |=> state_r == ST_DEV;
    endproperty
    a_start_dev: assert property (p_start_dev)
        else $error("start did not open address phase");

    property p_busy_nack;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ST_WRITE) ##1 (state_r == ST_WRITE) |-> !ack_en_r;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("acknowledge enabled during write cycle");

    property p_stop_standby;
        @(posedge clk) disable iff (!rst_n)
        (stop_ev_r && state_r != ST_WRITE && !go_write)
            |=> status.standby;
    endproperty
    a_stop_standby: assert property (p_stop_standby)
        else $error("stop did not return to standby");

    property p_write_hold;
        @(posedge clk) disable iff (!rst_n)
        go_write |=> status.busy [*4];
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write cycle ended early");

    property p_perm_refuse;
        @(posedge clk) disable iff (!rst_n)
        (byte_ev_r && state_r == ST_DEV && perm_r && sel == SEL_WP)
            |=> !ack_en_r && state_r == ST_IDLE;
    endproperty
    a_perm_refuse: assert property (p_perm_refuse)
        else $error("protect selector acknowledged after programming");

    property p_mismatch;
        @(posedge clk) disable iff (!rst_n)
        (byte_ev_r && state_r == ST_DEV && sel == SEL_ARRAY && !match)
            |=> !ack_en_r && status.standby;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatched address acknowledged");

    property p_perm_sticky;
        @(posedge clk) disable iff (!rst_n)
        (loaded_r && perm_r) |=> perm_r;
    endproperty
    a_perm_sticky: assert property (p_perm_sticky)
        else $error("permanent protection cleared");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        (byte_ev_r && state_r == ST_DATA) |=>
            waddr_r[7:4] == $past(waddr_r[7:4]) &&
            waddr_r[3:0] == $past(waddr_r[3:0]) + 4'h1;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("page address did not wrap in page");

    property p_ack_slot;
        @(posedge scl_clk) disable iff (!rst_n)
        sda_oe_r |-> bit_cnt_r == ACK_SLOT;
    endproperty
    a_ack_slot: assert property (p_ack_slot)
        else $error("data line driven outside acknowledge slot");

    c_byte_write: cover property (@(posedge clk) disable iff (!rst_n)
        go_write && op_r == OP_ARRAY);
    c_rev_set: cover property (@(posedge clk) disable iff (!rst_n)
        go_write && op_r == OP_REV_SET);
    c_page_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        byte_ev_r && state_r == ST_DATA && waddr_r[3:0] == 4'hf);
    c_poll_busy: cover property (@(posedge clk) disable iff (!rst_n)
        start_ev_r && state_r == ST_WRITE);

endmodule

// File: testbench/serial_eeprom_wp_slave_test.sv
// Self-checking bench for the write-protected two-wire byte array slave.
// Assumes sewp_pkg and sewp_slave are compiled first.
`timescale 1ns/1ps

module serial_eeprom_wp_slave_test;
    import sewp_pkg::*;
    // Short write cycle keeps the run small; polls still fit inside it
    localparam int WR = 1000;
    localparam logic [3:0] MATCH = 4'b0101;
    logic            clk = 1'b0;
    logic            lclk = 1'b0;
    logic            rst_n;
    logic            scl_clk;
    logic            m_low;
    logic            sda_o;
    logic            sda_oe;
    logic            nv;
    logic [7:0]      dbg_addr;
    logic [7:0]      dbg_data;
    sewp_strap_type  straps;
    sewp_status_type status;
    logic [7:0]      mem_exp [256];
    logic [31:0]     seed = 32'h04079747;
    logic            pexp = 1'b0;
    logic            rexp = 1'b0;
    int              cyc = 0;
    int              fail_count = 0;
    int              checks_done = 0;
    wire             sda = ~(m_low | sda_oe);

    always #10 clk = ~clk;
    always #7.5 lclk = ~lclk;
    always @(posedge clk) cyc <= cyc + 1;

    sewp_master M (.lclk(lclk), .sda_in(sda), .scl_clk(scl_clk),
        .sda_low(m_low));

    sewp_slave #(.WR_CYCLES(WR)) DUT (.clk(clk), .rst_n(rst_n),
        .scl_clk(scl_clk), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .strap_pins(straps), .nv_perm_in(nv), .dbg_addr(dbg_addr),
        .dbg_data(dbg_data), .status(status));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic setst(input logic [3:0] v);
        @(negedge clk);
        straps = v;
        repeat (5) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        dbg_addr = a;
        repeat (2) @(negedge clk);
        chk("array", dbg_data, mem_exp[a]);
    endtask

    // One frame; n data bytes, a poll and the busy span when ex is set and n > 0
    task automatic wr(input logic [7:0] dev, input logic ex,
                      input logic [7:0] wa, input int n);
        logic       a;
        logic [7:0] d;
        int         t0;
        M.start();
        M.send(dev, a);
        chk("dev_ack", a, ex);
        if (ex && n > 0) begin
            M.send(wa, a);
            chk("word_ack", a, 1'b1);
            for (int i = 0; i < n; i++) begin
                seed = lfsr(seed);
                d = seed[7:0];
                M.send(d, a);
                chk("data_ack", a, 1'b1);
                if (dev[7:4] == SEL_ARRAY && !((pexp | rexp) && !wa[7])) begin
                    mem_exp[{wa[7:4], wa[3:0] + i[3:0]}] = d;
                end
            end
        end
        M.stop();
        if (ex && n > 0) begin
            t0 = cyc;
            chk("busy", status.busy, 1'b1);
            M.start();
            M.send(8'haa, a);
            chk("poll_ack", a, 1'b0);
            M.stop();
            while (status.busy === 1'b1 && cyc - t0 < 2 * WR) begin
                @(negedge clk);
            end
            chk("busy_len", 8'(cyc - t0 > WR - 30 && cyc - t0 <= WR),
                8'h1);
        end
        repeat (10) @(negedge clk);
        chk("standby", status.standby, 1'b1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] a;
        logic       r;
        logic [8:0] modes [4];
        modes = '{9'h0a1, 9'h03a, 9'h1ab, 9'h06b};
        rst_n = 1'b0;
        straps = MATCH;
        nv = 1'b0;
        dbg_addr = 8'h00;
        repeat (10) @(negedge clk);
        chk("rst_status", 8'(status), 8'h8);
        chk("rst_oe", sda_oe, 1'b0);
        chk("rst_sda_o", sda_o, 1'b0);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        // Mismatch, sensor, read and protect-read selectors
        for (int i = 0; i < 4; i++) begin
            wr(modes[i][7:0], modes[i][8], 8'h00, 0);
        end
        seed = lfsr(seed);
        a = seed[7:0] | 8'h80;
        wr(8'haa, 1'b1, a, 1);
        rd(a);
        seed = lfsr(seed);
        a = {1'b1, seed[6:4], 4'he};
        wr(8'haa, 1'b1, a, 18);
        for (int k = 0; k < 16; k++) begin
            rd({a[7:4], k[3:0]});
        end
        // Bus recovery, then a plain lower-half write
        M.start();
        repeat (9) M.put_bit(1'b1, r);
        M.start();
        M.stop();
        wr(8'haa, 1'b1, 8'h10, 1);
        rd(8'h10);
        setst(4'b1001);
        wr(CMD_REV_SET, 1'b1, 8'h00, 1);
        rexp = 1'b1;
        chk("rev_set", status.rev_wp, 1'b1);
        setst(MATCH);
        wr(8'haa, 1'b1, 8'h10, 1);
        rd(8'h10);
        setst(4'b1011);
        wr(CMD_REV_CLR, 1'b1, 8'h00, 1);
        rexp = 1'b0;
        chk("rev_clr", status.rev_wp, 1'b0);
        setst(MATCH);
        wr(8'h6a, 1'b1, 8'h00, 1);
        pexp = 1'b1;
        chk("perm", status.perm_wp, 1'b1);
        wr(8'h6a, 1'b0, 8'h00, 1);
        wr(8'haa, 1'b1, 8'h10, 1);
        rd(8'h10);
        // Power cycle restores the stored permanent flag
        nv = 1'b1;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("perm_keep", status.perm_wp, 1'b1);
        stop_test();
    end

    // Hang guard sized well beyond the expected run
    initial begin
        #1800000;
        fail_count++;
        stop_test();
    end
endmodule

// File: testbench/sewp_master.sv
// Behavioural two-wire bus master facing the slave's serial pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps

module sewp_master (
    input  wire logic lclk,
    input  wire logic sda_in,
    output logic      scl_clk,
    output logic      sda_low
);
    // ==========================================================
    // Idle bus: clock parked high, data released
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hw;
        repeat (20) @(posedge lclk);
    endtask

    // Data moves a few ticks after the clock falls
    task automatic put_bit(input logic b, output logic r);
        repeat (4) @(posedge lclk);
        sda_low = ~b;
        repeat (16) @(posedge lclk);
        scl_clk = 1'b1;
        repeat (10) @(posedge lclk);
        r = sda_in;
        repeat (10) @(posedge lclk);
        scl_clk = 1'b0;
    endtask

    // Every command opens with a start
    task automatic start;
        repeat (4) @(posedge lclk);
        sda_low = 1'b0;
        hw();
        scl_clk = 1'b1;
        hw();
        sda_low = 1'b1;
        hw();
        scl_clk = 1'b0;
    endtask

    // Writes and polls always end with a stop
    task automatic stop;
        repeat (4) @(posedge lclk);
        sda_low = 1'b1;
        hw();
        scl_clk = 1'b1;
        hw();
        sda_low = 1'b0;
        hw();
    endtask

    // MSB first, ninth clock released for the acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask
endmodule
